// >>> inc/eds_pkg.sv
// Package of constants and types for the Ethernet DMA status and irq block
package eds_pkg;

   // Register byte offsets on the Wishbone slave
   localparam logic [7:0] EDS_OFF_TX_POLL  = 8'h04;
   localparam logic [7:0] EDS_OFF_RX_POLL  = 8'h08;
   localparam logic [7:0] EDS_OFF_STATUS   = 8'h14;
   localparam logic [7:0] EDS_OFF_IRQ_EN   = 8'h1c;
   localparam logic [7:0] EDS_OFF_RX_WDOG  = 8'h24;
   localparam logic [7:0] EDS_OFF_TX_CDESC = 8'h48;
   localparam logic [7:0] EDS_OFF_RX_CDESC = 8'h4c;
   localparam logic [7:0] EDS_OFF_TX_CBUF  = 8'h50;
   localparam logic [7:0] EDS_OFF_RX_CBUF  = 8'h54;

   // Flag positions in the status and enable registers
   localparam int EDS_B_TX_DONE   = 0;
   localparam int EDS_B_TX_STOP   = 1;
   localparam int EDS_B_TX_NODESC = 2;
   localparam int EDS_B_TX_JABBER = 3;
   localparam int EDS_B_RX_OVFL   = 4;
   localparam int EDS_B_TX_UNDFL  = 5;
   localparam int EDS_B_RX_DONE   = 6;
   localparam int EDS_B_RX_NODESC = 7;
   localparam int EDS_B_RX_STOP   = 8;
   localparam int EDS_B_RX_WDTO   = 9;
   localparam int EDS_B_EARLY_TX  = 10;
   localparam int EDS_B_BUS_FAULT = 13;
   localparam int EDS_B_EARLY_RX  = 14;
   localparam int EDS_B_ABN_SUM   = 15;
   localparam int EDS_B_NORM_SUM  = 16;

   // Source groups feeding the two summaries
   localparam logic [16:0] EDS_NORMAL_SRC = 17'h0_4045;
   localparam logic [16:0] EDS_ABNORM_SRC = 17'h0_27ba;
   localparam logic [16:0] EDS_FLAG_MASK  = 17'h1_e7ff;

   // Descriptor word zero bits written back by the DMA
   localparam int EDS_D_OWN    = 31;
   localparam int EDS_D_TX_UF  = 1;
   localparam int EDS_D_TX_JAB = 14;
   localparam int EDS_D_RX_OF  = 11;

   // Jabber limits in bytes and watchdog scaling
   localparam logic [13:0] EDS_JAB_LIMIT   = 14'h0800;
   localparam logic [13:0] EDS_JAB_LIMIT_J = 14'h2800;
   localparam logic [7:0]  EDS_WDOG_SCALE  = 8'h00;

   // Process state codes shown in the status register
   localparam logic [2:0] EDS_CODE_STOP  = 3'h0;
   localparam logic [2:0] EDS_CODE_FETCH = 3'h1;
   localparam logic [2:0] EDS_CODE_XFER  = 3'h7;
   localparam logic [2:0] EDS_CODE_SUSP  = 3'h4;

   typedef enum logic [1:0] {
      EDS_ST_STOP  = 2'h0,
      EDS_ST_FETCH = 2'h1,
      EDS_ST_XFER  = 2'h3,
      EDS_ST_SUSP  = 2'h2
   } eds_proc_t;

   typedef struct packed {
      eds_proc_t        tx_st;
      eds_proc_t        rx_st;
      logic             tx_en_d;
      logic             rx_en_d;
      logic [13:0]      tx_bytes;
      logic             rx_prev_host;
      logic             rx_of_mark;
      logic [16:0]      sts;
      logic [2:0]       err;
      logic [16:0]      inten;
      logic [7:0]       wdog_val;
      logic [15:0]      wdog_cnt;
      logic             wdog_run;
      logic [3:0][31:0] ptr;
      logic [31:0]      wb_dat;
      logic             wb_ack;
      logic             irq;
      logic             tx_fetch;
      logic             rx_fetch;
      logic             tx_wb;
      logic [31:0]      tx_word;
      logic             rx_wb;
      logic [31:0]      rx_word;
   } eds_state_t;

endpackage

// >>> verilog/eds_dma_status.sv
// Status, interrupt, watchdog and pointer logic of the Ethernet DMA
`timescale 1ns/1ps
`default_nettype none

module eds_dma_status (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   input  wire logic        jumbo_enable_i,
   input  wire logic        tx_enable_i,
   output logic             tx_fetch_o,
   input  wire logic        tx_desc_valid_i,
   input  wire logic        tx_desc_own_i,
   input  wire logic        tx_byte_i,
   input  wire logic        tx_frame_done_i,
   input  wire logic        tx_underflow_i,
   input  wire logic [31:0] tx_frame_status_i,
   output logic             tx_desc_wb_o,
   output logic      [31:0] tx_desc_word0_o,
   input  wire logic        rx_enable_i,
   output logic             rx_fetch_o,
   input  wire logic        rx_desc_valid_i,
   input  wire logic        rx_desc_own_i,
   input  wire logic        rx_frame_start_i,
   input  wire logic        rx_frame_done_i,
   input  wire logic        rx_irq_disable_i,
   input  wire logic        rx_overflow_i,
   input  wire logic        rx_partial_i,
   input  wire logic [31:0] rx_frame_status_i,
   output logic             rx_desc_wb_o,
   output logic      [31:0] rx_desc_word0_o,
   input  wire logic        rx_wdog_timeout_i,
   input  wire logic        early_tx_i,
   input  wire logic        early_rx_i,
   input  wire logic        bus_fault_i,
   input  wire logic [2:0]  bus_fault_kind_i,
   input  wire logic [3:0]  ptr_load_i,
   input  wire logic [31:0] ptr_value_i
);
   import eds_pkg::*;

   eds_state_t r;
   eds_state_t n;

   function automatic logic [31:0] byte_mask(input logic [3:0] sel);
      byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   function automatic logic [2:0] state_code(input eds_proc_t st);
      case (st)
         EDS_ST_STOP:  state_code = EDS_CODE_STOP;
         EDS_ST_FETCH: state_code = EDS_CODE_FETCH;
         EDS_ST_XFER:  state_code = EDS_CODE_XFER;
         EDS_ST_SUSP:  state_code = EDS_CODE_SUSP;
         default:      state_code = EDS_CODE_STOP;
      endcase
   endfunction

   logic        bus_hit;
   logic        bus_wr;
   logic [31:0] wmask;
   logic        tx_poll;
   logic        rx_poll;
   logic [16:0] set;
   logic [16:0] clr;
   logic [16:0] flags;
   logic [16:0] live;
   logic [13:0] jab_limit;
   logic        wdog_load;

   always_comb begin
      n = r;
      set = '0;
      clr = '0;
      flags = '0;
      live = '0;
      wdog_load = 1'b0;
      // Ack only every other cycle so a held strobe is taken again on every second cycle
      bus_hit = wb_cyc_i & wb_stb_i & ~r.wb_ack;
      bus_wr = bus_hit & wb_we_i;
      wmask = byte_mask(wb_sel_i);
      // Any written value counts as a poll demand
      tx_poll = bus_wr & (wb_adr_i == EDS_OFF_TX_POLL);
      rx_poll = bus_wr & (wb_adr_i == EDS_OFF_RX_POLL);
      jab_limit = jumbo_enable_i ? EDS_JAB_LIMIT_J : EDS_JAB_LIMIT;
      n.wb_ack = bus_hit;
      n.tx_wb = 1'b0;
      n.rx_wb = 1'b0;
      n.tx_en_d = tx_enable_i;
      n.rx_en_d = rx_enable_i;

      // Transmit process
      case (r.tx_st)
         EDS_ST_STOP: begin
            // A jabber stop holds until software re-arms transmit
            if (tx_enable_i & ~r.tx_en_d) begin
               n.tx_st = EDS_ST_FETCH;
            end
         end
         EDS_ST_FETCH: begin
            if (tx_desc_valid_i) begin
               if (tx_desc_own_i) begin
                  n.tx_st = EDS_ST_XFER;
                  n.tx_bytes = '0;
               end else begin
                  n.tx_st = EDS_ST_SUSP;
                  set[EDS_B_TX_NODESC] = 1'b1;
               end
            end
         end
         EDS_ST_XFER: begin
            if (tx_underflow_i) begin
               n.tx_word = tx_frame_status_i;
               n.tx_word[EDS_D_OWN] = 1'b0;
               n.tx_word[EDS_D_TX_UF] = 1'b1;
               n.tx_wb = 1'b1;
               set[EDS_B_TX_UNDFL] = 1'b1;
               n.tx_st = EDS_ST_SUSP;
            end else if (tx_byte_i & (r.tx_bytes == jab_limit)) begin
               n.tx_word = tx_frame_status_i;
               n.tx_word[EDS_D_OWN] = 1'b0;
               n.tx_word[EDS_D_TX_JAB] = 1'b1;
               n.tx_wb = 1'b1;
               set[EDS_B_TX_JABBER] = 1'b1;
               n.tx_st = EDS_ST_STOP;
            end else if (tx_frame_done_i) begin
               n.tx_word = tx_frame_status_i;
               n.tx_word[EDS_D_OWN] = 1'b0;
               n.tx_wb = 1'b1;
               set[EDS_B_TX_DONE] = 1'b1;
               n.tx_st = EDS_ST_FETCH;
            end else if (tx_byte_i) begin
               n.tx_bytes = r.tx_bytes + 14'h0001;
            end
         end
         EDS_ST_SUSP: begin
            if (tx_poll) begin
               n.tx_st = EDS_ST_FETCH;
            end
         end
         default: begin
            n.tx_st = EDS_ST_STOP;
         end
      endcase
      if (!tx_enable_i) begin
         n.tx_st = EDS_ST_STOP;
      end
      if (n.tx_st == EDS_ST_STOP && r.tx_st != EDS_ST_STOP) begin
         set[EDS_B_TX_STOP] = 1'b1;
      end
      n.tx_fetch = (n.tx_st == EDS_ST_FETCH);

      // Receive process
      case (r.rx_st)
         EDS_ST_STOP: begin
            if (rx_enable_i & ~r.rx_en_d) begin
               n.rx_st = EDS_ST_FETCH;
            end
         end
         EDS_ST_FETCH: begin
            if (rx_desc_valid_i) begin
               n.rx_prev_host = ~rx_desc_own_i;
               if (rx_desc_own_i) begin
                  n.rx_st = EDS_ST_XFER;
                  n.rx_of_mark = 1'b0;
               end else begin
                  n.rx_st = EDS_ST_SUSP;
                  // Repeated refetches of a host descriptor flag once
                  set[EDS_B_RX_NODESC] = ~r.rx_prev_host;
               end
            end
         end
         EDS_ST_XFER: begin
            if (rx_overflow_i) begin
               set[EDS_B_RX_OVFL] = 1'b1;
               n.rx_of_mark = r.rx_of_mark | rx_partial_i;
            end
            if (rx_frame_done_i) begin
               n.rx_word = rx_frame_status_i;
               n.rx_word[EDS_D_OWN] = 1'b0;
               n.rx_word[EDS_D_RX_OF] = n.rx_of_mark;
               n.rx_wb = 1'b1;
               n.rx_st = EDS_ST_FETCH;
               if (!rx_irq_disable_i) begin
                  set[EDS_B_RX_DONE] = 1'b1;
                  n.wdog_run = 1'b0;
               end else if (r.wdog_val != 8'h00) begin
                  n.wdog_cnt = {r.wdog_val, EDS_WDOG_SCALE};
                  n.wdog_run = 1'b1;
                  wdog_load = 1'b1;
               end
            end
         end
         EDS_ST_SUSP: begin
            if (rx_poll | rx_frame_start_i) begin
               n.rx_st = EDS_ST_FETCH;
            end
         end
         default: begin
            n.rx_st = EDS_ST_STOP;
         end
      endcase
      if (!rx_enable_i) begin
         n.rx_st = EDS_ST_STOP;
      end
      if (n.rx_st == EDS_ST_STOP && r.rx_st != EDS_ST_STOP) begin
         set[EDS_B_RX_STOP] = 1'b1;
      end
      n.rx_fetch = (n.rx_st == EDS_ST_FETCH);

      // Receive interrupt watchdog, only when not just reloaded or reset
      if (r.wdog_run && n.wdog_run && !wdog_load) begin
         if (r.wdog_cnt == 16'h0001) begin
            set[EDS_B_RX_DONE] = 1'b1;
            n.wdog_run = 1'b0;
         end else begin
            n.wdog_cnt = r.wdog_cnt - 16'h0001;
         end
      end

      // Events from the data path
      set[EDS_B_RX_WDTO] = rx_wdog_timeout_i;
      set[EDS_B_EARLY_TX] = early_tx_i;
      set[EDS_B_EARLY_RX] = early_rx_i;
      set[EDS_B_BUS_FAULT] = bus_fault_i;
      if (bus_fault_i) begin
         n.err = bus_fault_kind_i;
      end

      // Software writes
      if (bus_wr && wb_adr_i == EDS_OFF_STATUS) begin
         clr = wb_dat_i[16:0] & wmask[16:0] & EDS_FLAG_MASK;
      end
      if (bus_wr && wb_adr_i == EDS_OFF_IRQ_EN) begin
         n.inten = ((r.inten & ~wmask[16:0]) | (wb_dat_i[16:0] & wmask[16:0]))
                   & EDS_FLAG_MASK;
      end
      if (bus_wr && wb_adr_i == EDS_OFF_RX_WDOG && wb_sel_i[0]) begin
         n.wdog_val = wb_dat_i[7:0];
      end

      // Flag update; a new event beats a same-cycle clear
      flags = (r.sts & ~clr) | set;
      if (set[EDS_B_RX_DONE] && !set[EDS_B_EARLY_RX]) begin
         flags[EDS_B_EARLY_RX] = 1'b0;
      end
      live = flags & r.inten;
      flags[EDS_B_NORM_SUM] = (r.sts[EDS_B_NORM_SUM] & ~clr[EDS_B_NORM_SUM])
         | (|(live & EDS_NORMAL_SRC)
            & r.inten[EDS_B_NORM_SUM]);
      flags[EDS_B_ABN_SUM] = (r.sts[EDS_B_ABN_SUM] & ~clr[EDS_B_ABN_SUM])
         | (|(live & EDS_ABNORM_SRC)
            & r.inten[EDS_B_ABN_SUM]);
      n.sts = flags;
      n.irq = flags[EDS_B_NORM_SUM] | flags[EDS_B_ABN_SUM];

      // Pointers follow the DMA only; bus writes never reach them
      for (int i = 0; i < 4; i++) begin
         if (ptr_load_i[i]) begin
            n.ptr[i] = ptr_value_i;
         end
      end

      // Read data; unmapped offsets read as zero
      n.wb_dat = '0;
      if (bus_hit && !wb_we_i) begin
         case (wb_adr_i)
            EDS_OFF_STATUS: begin
               n.wb_dat = {6'h00, r.err, state_code(r.tx_st),
                           state_code(r.rx_st), r.sts};
            end
            EDS_OFF_IRQ_EN: begin
               n.wb_dat = {15'h0000, r.inten};
            end
            EDS_OFF_RX_WDOG: begin
               n.wb_dat = {24'h00_0000, r.wdog_val};
            end
            EDS_OFF_TX_CDESC: begin
               n.wb_dat = r.ptr[0];
            end
            EDS_OFF_RX_CDESC: begin
               n.wb_dat = r.ptr[1];
            end
            EDS_OFF_TX_CBUF: begin
               n.wb_dat = r.ptr[2];
            end
            EDS_OFF_RX_CBUF: begin
               n.wb_dat = r.ptr[3];
            end
            default: begin
               n.wb_dat = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign wb_dat_o        = r.wb_dat;
   assign wb_ack_o        = r.wb_ack;
   assign irq_o           = r.irq;
   assign tx_fetch_o      = r.tx_fetch;
   assign tx_desc_wb_o    = r.tx_wb;
   assign tx_desc_word0_o = r.tx_word;
   assign rx_fetch_o      = r.rx_fetch;
   assign rx_desc_wb_o    = r.rx_wb;
   assign rx_desc_word0_o = r.rx_word;

endmodule

`default_nettype wire

// >>> sim/eds_dma_status_monitor.sv
// Bus and descriptor handshake checks for the DMA status block
`timescale 1ns/1ps
`default_nettype none
module eds_dma_status_monitor
   import eds_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic        tx_enable_i,
   input wire logic        tx_fetch_o,
   input wire logic        tx_desc_valid_i,
   input wire logic        tx_desc_own_i,
   input wire logic        tx_desc_wb_o,
   input wire logic [31:0] tx_desc_word0_o,
   input wire logic        rx_fetch_o,
   input wire logic        rx_desc_valid_i,
   input wire logic        rx_desc_own_i,
   input wire logic        rx_desc_wb_o,
   input wire logic [31:0] rx_desc_word0_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_tx_host;
      tx_fetch_o && tx_desc_valid_i && !tx_desc_own_i;
   endsequence
   sequence s_rx_host;
      rx_fetch_o && rx_desc_valid_i && !rx_desc_own_i;
   endsequence
   property p_ack_lat;
      s_take |=> wb_ack_o;
   endproperty
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
   endproperty
   property p_tx_nodesc;
      s_tx_host |=> !tx_fetch_o;
   endproperty
   property p_rx_nodesc;
      s_rx_host |=> !rx_fetch_o;
   endproperty
   property p_tx_done;
      tx_desc_wb_o && tx_enable_i && !tx_desc_word0_o[EDS_D_TX_UF]
         && !tx_desc_word0_o[EDS_D_TX_JAB]
         |-> !tx_desc_word0_o[EDS_D_OWN] && tx_fetch_o;
   endproperty
   property p_tx_uf;
      tx_desc_wb_o && tx_desc_word0_o[EDS_D_TX_UF]
         |-> !tx_fetch_o ##1 !tx_fetch_o;
   endproperty
   property p_jab;
      tx_desc_wb_o && tx_desc_word0_o[EDS_D_TX_JAB] |-> !tx_fetch_o [*3];
   endproperty
   property p_rx_wb;
      rx_desc_wb_o |-> !rx_desc_word0_o[EDS_D_OWN];
   endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
   a_dat_idle: assert property (p_dat_idle) else $error("data idle");
   a_tx_nodesc: assert property (p_tx_nodesc)
      else $error("tx not suspended");
   a_rx_nodesc: assert property (p_rx_nodesc)
      else $error("rx not suspended");
   a_tx_done: assert property (p_tx_done)
      else $error("tx close wrong");
   a_tx_uf: assert property (p_tx_uf)
      else $error("underflow running");
   a_jab: assert property (p_jab)
      else $error("jabber running");
   a_rx_wb: assert property (p_rx_wb)
      else $error("rx owner kept");
endmodule
bind eds_dma_status eds_dma_status_monitor i_mon (.clk_i, .rst_i,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .tx_enable_i, .tx_fetch_o,
   .tx_desc_valid_i, .tx_desc_own_i, .tx_desc_wb_o, .tx_desc_word0_o,
   .rx_fetch_o, .rx_desc_valid_i, .rx_desc_own_i, .rx_desc_wb_o,
   .rx_desc_word0_o);
`default_nettype wire

// >>> sim/eds_desc_model.sv
// Descriptor memory model answering fetch requests
`timescale 1ns/1ps
`default_nettype none
module eds_desc_model (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic fetch_i,
   input  wire logic own_i,
   output logic      valid_o,
   output logic      own_o
);
   logic [1:0] wait_reg;
   // Owner line toggles outside answers so a stale value never helps
   always @(posedge clk_i) begin
      valid_o <= '0;
      own_o <= rst_i ? '0 : ~own_o;
      if (rst_i || !fetch_i || valid_o) begin
         wait_reg <= 2'($urandom_range(3));
      end else if (wait_reg == 2'h0) begin
         valid_o <= '1;
         own_o <= own_i;
      end else begin
         wait_reg <= wait_reg - 2'h1;
      end
   end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the DMA status and irq block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import eds_pkg::*;
   logic clk_i = '0, rst_i = '1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
   logic [7:0] wb_adr_i = '0;
   logic [3:0] wb_sel_i = '0, src = '0, ptr_load_i = '0;
   logic [31:0] wb_dat_i = '0, wb_dat_o, rd, st, v, e, tx_w, rx_w;
   logic wb_ack_o, irq_o, tx_fetch_o, rx_fetch_o, tx_desc_wb_o, rx_desc_wb_o;
   logic tx_desc_valid_i, tx_desc_own_i, rx_desc_valid_i, rx_desc_own_i;
   logic [31:0] tx_desc_word0_o, rx_desc_word0_o, ptr_value_i = '0;
   logic [31:0] tx_frame_status_i = '0, rx_frame_status_i = '0;
   logic jumbo_enable_i = '0, tx_enable_i = '0, tx_byte_i = '0;
   logic tx_frame_done_i = '0, tx_underflow_i = '0, rx_enable_i = '0;
   logic rx_frame_start_i = '0, rx_frame_done_i = '0, rx_irq_disable_i = '0;
   logic rx_overflow_i = '0, rx_partial_i = '0, tx_own = '0, rx_own = '0;
   logic [2:0] bus_fault_kind_i = '0;
   int bad_count = 0, n_tests = 0, ticks = 0, lim, sm;
   int sb [4] = '{EDS_B_RX_WDTO, EDS_B_EARLY_TX, EDS_B_BUS_FAULT,
                  EDS_B_EARLY_RX};
   logic [7:0] ofs [5] = '{EDS_OFF_TX_CDESC, EDS_OFF_RX_CDESC,
                           EDS_OFF_TX_CBUF, EDS_OFF_RX_CBUF, 8'h30};
   eds_dma_status i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o,
      .jumbo_enable_i, .tx_enable_i, .tx_fetch_o, .tx_desc_valid_i,
      .tx_desc_own_i, .tx_byte_i, .tx_frame_done_i, .tx_underflow_i,
      .tx_frame_status_i, .tx_desc_wb_o, .tx_desc_word0_o, .rx_enable_i,
      .rx_fetch_o, .rx_desc_valid_i, .rx_desc_own_i, .rx_frame_start_i,
      .rx_frame_done_i, .rx_irq_disable_i, .rx_overflow_i, .rx_partial_i,
      .rx_frame_status_i, .rx_desc_wb_o, .rx_desc_word0_o,
      .rx_wdog_timeout_i(src[0]), .early_tx_i(src[1]), .bus_fault_i(src[2]),
      .early_rx_i(src[3]), .bus_fault_kind_i, .ptr_load_i, .ptr_value_i);
   eds_desc_model i_txm (.clk_i, .rst_i, .fetch_i(tx_fetch_o), .own_i(tx_own),
      .valid_o(tx_desc_valid_i), .own_o(tx_desc_own_i));
   eds_desc_model i_rxm (.clk_i, .rst_i, .fetch_i(rx_fetch_o), .own_i(rx_own),
      .valid_o(rx_desc_valid_i), .own_o(rx_desc_own_i));
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (tx_desc_wb_o) tx_w <= tx_desc_word0_o;
      if (rx_desc_wb_o) rx_w <= rx_desc_word0_o;
      ticks <= ticks + 1;
      if (ticks == 60000) begin
         bad_count = bad_count + 1;
         final_report;
      end
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, g);
      n_tests++;
      if (g !== ex) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, ex, g);
      end
   endtask
   // Request held until ack is sampled high, then released
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      wb_sel_i <= 4'hf;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
   endtask
   task automatic clr;
      wb('1, EDS_OFF_STATUS, 32'h0001_ffff);
   endtask
   function automatic logic [31:0] xs(int sh, logic [2:0] c, int f, logic fv);
      return (32'(c) << sh) | (32'(fv) << f);
   endfunction
   task automatic ps(input int sh, input logic [2:0] c, input int f,
                     input logic fv, input string nm);
      wb('0, EDS_OFF_STATUS, '0);
      chk(nm, xs(sh, c, f, fv), rd & ((32'h7 << sh) | (32'h1 << f)));
   endtask
   task automatic send(input int n, input int k);
      @(posedge clk_i);
      st = ($urandom | 32'h8000_0000) & 32'hffff_bffd;
      tx_frame_status_i <= st;
      tx_byte_i <= '1;
      repeat (n) @(posedge clk_i);
      tx_byte_i <= '0;
      tx_frame_done_i <= k == 1;
      tx_underflow_i <= k == 2;
      @(posedge clk_i);
      {tx_frame_done_i, tx_underflow_i} <= 2'h0;
      repeat (6) @(posedge clk_i);
   endtask
   task automatic rxf(input logic dis, input logic ovf);
      @(posedge clk_i);
      st = $urandom & 32'h7fff_f7ff;
      rx_frame_status_i <= st;
      {rx_overflow_i, rx_partial_i} <= {ovf, ovf};
      @(posedge clk_i);
      {rx_overflow_i, rx_partial_i} <= 2'h0;
      {rx_frame_done_i, rx_irq_disable_i} <= {1'b1, dis};
      @(posedge clk_i);
      rx_frame_done_i <= '0;
      repeat (8) @(posedge clk_i);
   endtask
   initial begin
      v = $urandom(32'h0000_0764);
      repeat (12) @(posedge clk_i);
      rst_i <= '0;
      for (int p = 0; p < 5; p++) begin
         wb('1, ofs[p], '1);
         wb('0, ofs[p], '0);
         chk("reset ptr", 0, rd);
      end
      for (int p = 0; p < 4; p++) begin
         v = $urandom;
         @(posedge clk_i);
         ptr_value_i <= v;
         ptr_load_i <= 4'(1 << p);
         @(posedge clk_i);
         ptr_load_i <= '0;
         wb('0, ofs[p], '0);
         chk("ptr", v, rd);
      end
      v = $urandom;
      wb('1, EDS_OFF_IRQ_EN, v);
      wb('0, EDS_OFF_IRQ_EN, '0);
      chk("enable", v & 32'(EDS_FLAG_MASK), rd);
      for (int s = 0; s < 4; s++) begin
         for (int k = 0; k < 4; k++) begin
            sm = (s == 3) ? EDS_B_NORM_SUM : EDS_B_ABN_SUM;
            e = '0;
            e[sb[s]] = k[0];
            e[sm] = k[1];
            wb('1, EDS_OFF_IRQ_EN, e);
            @(posedge clk_i);
            src[s] <= '1;
            bus_fault_kind_i <= 3'($urandom);
            @(posedge clk_i);
            src[s] <= '0;
            repeat (2) @(posedge clk_i);
            chk("irq", 32'(k == 3), irq_o);
            wb('1, EDS_OFF_STATUS, '0);
            wb('0, EDS_OFF_STATUS, '0);
            e[sm] = k == 3;
            e[sb[s]] = '1;
            chk("flags", e, rd[16:0]);
            if (s == 2) begin
               chk("fault kind", bus_fault_kind_i, rd[25:23]);
            end
            clr;
            wb('0, EDS_OFF_STATUS, '0);
            chk("clear", 0, rd & 32'h0001_ffff);
            chk("irq off", 0, irq_o);
         end
      end
      wb('1, EDS_OFF_IRQ_EN, 32'h0001_ffff);
      tx_enable_i <= '1;
      repeat (12) @(posedge clk_i);
      ps(20, EDS_CODE_SUSP, EDS_B_TX_NODESC, '1, "tx nodesc");
      clr;
      wb('1, EDS_OFF_TX_POLL, $urandom);
      repeat (8) @(posedge clk_i);
      ps(20, EDS_CODE_SUSP, EDS_B_TX_NODESC, '1, "tx repoll");
      tx_own <= '1;
      wb('1, EDS_OFF_TX_POLL, $urandom);
      repeat (8) @(posedge clk_i);
      ps(20, EDS_CODE_XFER, EDS_B_TX_DONE, '0, "tx resume");
      send(5, 2);
      chk("uf mark", 1, tx_w[EDS_D_TX_UF]);
      ps(20, EDS_CODE_SUSP, EDS_B_TX_UNDFL, '1, "tx uf");
      wb('1, EDS_OFF_TX_POLL, '0);
      repeat (8) @(posedge clk_i);
      for (int j = 0; j < 2; j++) begin
         lim = j ? int'(EDS_JAB_LIMIT_J) : int'(EDS_JAB_LIMIT);
         jumbo_enable_i <= j[0];
         send(lim, 1);
         chk("tx word", st & 32'h7fff_ffff, tx_w);
         ps(20, EDS_CODE_XFER, EDS_B_TX_DONE, '1, "tx done");
         send(lim + 1, 0);
         chk("jab mark", 1, tx_w[EDS_D_TX_JAB]);
         ps(20, EDS_CODE_STOP, EDS_B_TX_JABBER, '1, "jab");
         ps(20, EDS_CODE_STOP, EDS_B_TX_STOP, '1, "tx stop");
         tx_enable_i <= '0;
         @(posedge clk_i);
         tx_enable_i <= '1;
         repeat (10) @(posedge clk_i);
      end
      clr;
      rx_enable_i <= '1;
      repeat (12) @(posedge clk_i);
      ps(17, EDS_CODE_SUSP, EDS_B_RX_NODESC, '1, "rx nodesc");
      clr;
      wb('1, EDS_OFF_RX_POLL, '0);
      repeat (8) @(posedge clk_i);
      ps(17, EDS_CODE_SUSP, EDS_B_RX_NODESC, '0, "rx nodesc 2");
      rx_own <= '1;
      @(posedge clk_i);
      rx_frame_start_i <= '1;
      @(posedge clk_i);
      rx_frame_start_i <= '0;
      repeat (10) @(posedge clk_i);
      ps(17, EDS_CODE_XFER, EDS_B_RX_DONE, '0, "rx resume");
      @(posedge clk_i);
      src[3] <= '1;
      @(posedge clk_i);
      src[3] <= '0;
      rxf(0, 0);
      ps(17, EDS_CODE_XFER, EDS_B_EARLY_RX, '0, "early rx clr");
      chk("rx word", st, rx_w);
      ps(17, EDS_CODE_XFER, EDS_B_RX_DONE, '1, "rx done");
      rxf(0, 1);
      chk("rx of word", st | 32'h0000_0800, rx_w);
      ps(17, EDS_CODE_XFER, EDS_B_RX_OVFL, '1, "rx ovfl");
      wb('1, EDS_OFF_RX_WDOG, 32'h0000_0002);
      wb('0, EDS_OFF_RX_WDOG, '0);
      chk("wdog val", 2, rd);
      clr;
      rxf(1, 0);
      repeat (480) @(posedge clk_i);
      ps(17, EDS_CODE_XFER, EDS_B_RX_DONE, '0, "wdog early");
      repeat (40) @(posedge clk_i);
      ps(17, EDS_CODE_XFER, EDS_B_RX_DONE, '1, "wdog end");
      clr;
      repeat (600) @(posedge clk_i);
      ps(17, EDS_CODE_XFER, EDS_B_RX_DONE, '0, "wdog halt");
      rxf(1, 0);
      rxf(0, 0);
      clr;
      repeat (600) @(posedge clk_i);
      ps(17, EDS_CODE_XFER, EDS_B_RX_DONE, '0, "wdog cancel");
      rx_enable_i <= '0;
      repeat (4) @(posedge clk_i);
      ps(17, EDS_CODE_STOP, EDS_B_RX_STOP, '1, "rx stop");
      final_report;
   end
endmodule
`default_nettype wire
